// File: src/chan_cfg_pkg.sv
// package: register layouts, reset values and encodings for channel trim and sequencing
package chan_cfg_pkg;

  localparam int NUM_CHAN = 2;

  // command selector for the register port (no offsets printed)
  localparam logic [1:0] SEL_CHANNEL_CONFIG = 2'h0;
  localparam logic [1:0] SEL_AUX_FAULT_OV = 2'h1;
  localparam logic [1:0] SEL_AUX_FAULT_UV = 2'h2;

  // channel_config field positions
  localparam int BIT_CHAINED_START = 14;
  localparam int BIT_SERVO_CONT = 7;
  localparam int BIT_SERVO_ON_WARN = 6;
  localparam int POS_DAC_MODE = 4;
  localparam int BIT_RSVD_ONE = 3;
  localparam int BIT_SOFT_PULLDOWN = 2;
  localparam int BIT_DAC_GAIN = 1;
  localparam int BIT_DAC_POL = 0;
  localparam int BIT_RSVD_ZERO = 9;

  // reset values
  localparam logic [15:0] CHANNEL_CONFIG_RST = 16'h0008;
  localparam logic [7:0] AUX_SELECT_RST = 8'h00;
  localparam logic [15:0] CHANNEL_CONFIG_RO_MASK = 16'hfdf7;

  // timing: soft-connect ramp length
  localparam int SOFT_CONNECT_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SOFT_CONNECT_CYC = (SOFT_CONNECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0]
  {
    DAC_SERVO = 2'b00,
    DAC_OFF = 2'b01,
    DAC_DIRECT = 2'b10,
    DAC_SOFT = 2'b11
  } dac_mode_t;

  typedef struct packed
  {
    logic chained_start;
    logic servo_cont;
    logic servo_on_warn;
    dac_mode_t dac_mode;
    logic soft_pulldown;
    logic dac_gain;
    logic dac_pol;
  } chan_cfg_t;

  // per-channel status from the supervisor core
  typedef struct packed
  {
    logic on_cmd;
    logic rise_done;
    logic soft_stop;
    logic fault_off;
    logic ov_fault;
    logic uv_fault;
    logic warn_hit;
    logic control_in;
    logic retry_req;
    logic fault0_in;
  } chan_stat_t;

  // per-channel trim drive
  typedef struct packed
  {
    logic dac_connect;
    logic soft_ramp;
    logic servo_active;
    logic gain_high;
    logic pol_noninv;
    logic use_boot_code;
    logic code_write_ok;
  } trim_ctl_t;

endpackage : chan_cfg_pkg

// File: src/chan_trim_seq.sv
// one channel: trim dac attachment, enable pull-down style and chained start
`timescale 1ns/100ps
module chan_trim_seq
(
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire chan_cfg_pkg::chan_cfg_t cfg_i,
  input wire logic cfg_loaded_i,
  input wire chan_cfg_pkg::chan_stat_t stat_i,
  output chan_cfg_pkg::trim_ctl_t trim_o,
  output logic start_ok_o,
  output logic en_fast_pd_o,
  output logic en_weak_pd_o,
  output logic fault0_event_o
);

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_RAMP = 2'b01,
    ST_LIVE = 2'b10
  } conn_state_t;

  conn_state_t state_r;
  conn_state_t state_nxt;
  logic [$clog2(chan_cfg_pkg::SOFT_CONNECT_CYC+1)-1:0] ramp_cnt_r;
  logic boot_r;
  logic servo_r;
  logic fault0_r;
  logic active;
  logic want_soft;
  logic ramp_done;
  logic warn_reservo;

  // dac only matters once the channel is on and rise time is over
  assign active = stat_i.on_cmd & stat_i.rise_done;
  assign want_soft = (cfg_i.dac_mode == chan_cfg_pkg::DAC_SERVO) |
                     (cfg_i.dac_mode == chan_cfg_pkg::DAC_SOFT);
  assign ramp_done = (ramp_cnt_r == '0);
  assign warn_reservo = (cfg_i.dac_mode == chan_cfg_pkg::DAC_SERVO) & ~cfg_i.servo_cont &
                        cfg_i.servo_on_warn & stat_i.warn_hit;

  // connection sequencing
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
      begin
        if (active && cfg_i.dac_mode == chan_cfg_pkg::DAC_DIRECT)
          state_nxt = ST_LIVE;
        else if (active && want_soft)
          state_nxt = ST_RAMP;
      end
      ST_RAMP:
      begin
        if (!active || cfg_i.dac_mode == chan_cfg_pkg::DAC_OFF)
          state_nxt = ST_IDLE;
        else if (ramp_done)
          state_nxt = ST_LIVE;
      end
      ST_LIVE:
      begin
        if (!active || cfg_i.dac_mode == chan_cfg_pkg::DAC_OFF)
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // state, ramp timer, boot code and servo flags
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_r <= ST_IDLE;
      ramp_cnt_r <= '0;
      boot_r <= 1'b1;
      servo_r <= 1'b0;
      fault0_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r != ST_RAMP)
        ramp_cnt_r <= ($bits(ramp_cnt_r))'(chan_cfg_pkg::SOFT_CONNECT_CYC - 1); // zero is the last cycle
      else if (!ramp_done)
        ramp_cnt_r <= ramp_cnt_r - 1'b1;
      // boot value drives the dac after reset or reload; nothing clears it, even a code write
      boot_r <= cfg_loaded_i ? 1'b1 : boot_r;
      // servo once after connect, continuously, or again on a warning
      servo_r <= (cfg_i.dac_mode == chan_cfg_pkg::DAC_SERVO) && state_nxt == ST_LIVE &&
                 (state_r != ST_LIVE || cfg_i.servo_cont || warn_reservo);
      // fault line 0 event latches while the channel is down
      fault0_r <= stat_i.fault0_in | (fault0_r & ~stat_i.on_cmd);
    end
  end

  // trim outputs
  always_comb
  begin
    trim_o.dac_connect = (state_r == ST_LIVE);
    trim_o.soft_ramp = (state_r == ST_RAMP);
    trim_o.servo_active = servo_r;
    trim_o.gain_high = cfg_i.dac_gain;
    trim_o.pol_noninv = cfg_i.dac_pol;
    trim_o.use_boot_code = boot_r & (cfg_i.dac_mode == chan_cfg_pkg::DAC_DIRECT);
    trim_o.code_write_ok = (state_r == ST_LIVE) &
                           (cfg_i.dac_mode != chan_cfg_pkg::DAC_SERVO);
  end

  // chained start: control input acts as a sequence-on pin only, never turns a channel off
  assign start_ok_o = ~cfg_i.chained_start | stat_i.control_in |
                      stat_i.retry_req;

  // enable pin pull-down: weak only for a soft stop, fast otherwise
  assign en_weak_pd_o = ~stat_i.on_cmd & cfg_i.soft_pulldown & stat_i.soft_stop &
                        ~stat_i.fault_off;
  assign en_fast_pd_o = ~stat_i.on_cmd & ~en_weak_pd_o;
  assign fault0_event_o = fault0_r;

endmodule : chan_trim_seq

// File: src/channel_trim_and_sequence_config.sv
// top: configuration registers, two channels and auxiliary fault pin routing
//
// How it works
// - mode 00 soft-connects the dac if needed, then servos output to target.
// - mode 01 keeps the dac disconnected from the trim input.
// - mode 10 connects at once; after reset or reload uses the boot code.
// - mode 11 soft-connects; dac code may be written only after completion.
// - soft pull-down bit 0 means fast pull-down of enable whenever channel off.
// - bit 1 and soft stop off means weak current-limited pull-down on enable.
// - a fault-caused off always uses the fast pull-down.
// - gain bit picks 1.38V (0) or 2.65V (1) full-scale buffer gain.
// - polarity bit 0 inverting trim, 1 non-inverting trim.
// - chained start holds a slave until its control input shows power good.
// - no power-good sequence-off; host orders turn-off by delays.
// - chained start lets fault retries run while control input is low.
// - operation off-then-on clears faulted-off even with control input low.
// - after fault line 0 shutdown, raise alert with per-channel input event.
// - overvoltage select bit set pulls the auxiliary fault pin low fast.
// - undervoltage select bit set pulls the auxiliary fault pin low fast.
// - re-servo on warning when mode 00 and continuous servo is off.
// - chained start turns the control input into a sequence-on input only.
`timescale 1ns/100ps
module channel_trim_and_sequence_config
(
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic wr_en_i,
  input wire logic [1:0] reg_sel_i,
  input wire logic page_i,
  input wire logic [15:0] wr_data_i,
  input wire logic restore_i,
  output logic [15:0] rd_data_o,
  input wire chan_cfg_pkg::chan_stat_t stat0_i,
  input wire chan_cfg_pkg::chan_stat_t stat1_i,
  output chan_cfg_pkg::trim_ctl_t trim0_o,
  output chan_cfg_pkg::trim_ctl_t trim1_o,
  output logic [1:0] start_ok_o,
  output logic [1:0] en_fast_pd_o,
  output logic [1:0] en_weak_pd_o,
  output logic [1:0] fault0_event_o,
  output logic alert_n_o,
  output logic aux_fault_o,
  output logic aux_fault_oe_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] cfg_r [chan_cfg_pkg::NUM_CHAN];
  logic [7:0] ov_sel_r;
  logic [7:0] uv_sel_r;
  logic [15:0] rd_data_r;
  logic aux_r;
  logic loaded_r;
  logic wr_cfg;
  logic wr_ov;
  logic wr_uv;
  logic [15:0] rd_mux;
  chan_cfg_pkg::chan_cfg_t cfg_f [chan_cfg_pkg::NUM_CHAN];
  chan_cfg_pkg::chan_stat_t stat [chan_cfg_pkg::NUM_CHAN];
  chan_cfg_pkg::trim_ctl_t trim [chan_cfg_pkg::NUM_CHAN];
  logic [1:0] ov_hit;
  logic [1:0] uv_hit;

  assign stat[0] = stat0_i;
  assign stat[1] = stat1_i;
  assign trim0_o = trim[0];
  assign trim1_o = trim[1];

  // write decode
  assign wr_cfg = wr_en_i & (reg_sel_i == chan_cfg_pkg::SEL_CHANNEL_CONFIG);
  assign wr_ov = wr_en_i & (reg_sel_i == chan_cfg_pkg::SEL_AUX_FAULT_OV);
  assign wr_uv = wr_en_i & (reg_sel_i == chan_cfg_pkg::SEL_AUX_FAULT_UV);

  // read selection; unmapped selector reads zero
  assign rd_mux = (reg_sel_i == chan_cfg_pkg::SEL_CHANNEL_CONFIG) ? cfg_r[page_i] :
                  (reg_sel_i == chan_cfg_pkg::SEL_AUX_FAULT_OV) ? {8'h00, ov_sel_r} :
                  (reg_sel_i == chan_cfg_pkg::SEL_AUX_FAULT_UV) ? {8'h00, uv_sel_r} :
                  16'h0000;

  // register storage; bit 3 reads one, bit 9 reads zero
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cfg_r[0] <= chan_cfg_pkg::CHANNEL_CONFIG_RST;
      cfg_r[1] <= chan_cfg_pkg::CHANNEL_CONFIG_RST;
      ov_sel_r <= chan_cfg_pkg::AUX_SELECT_RST;
      uv_sel_r <= chan_cfg_pkg::AUX_SELECT_RST;
      rd_data_r <= 16'h0000;
      loaded_r <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
        cfg_r[page_i] <= (wr_data_i & chan_cfg_pkg::CHANNEL_CONFIG_RO_MASK) |
                         chan_cfg_pkg::CHANNEL_CONFIG_RST;
      if (wr_ov)
        ov_sel_r <= {6'h00, wr_data_i[1:0]};
      if (wr_uv)
        uv_sel_r <= {6'h00, wr_data_i[1:0]};
      rd_data_r <= rd_mux;
      loaded_r <= restore_i;
    end
  end

  assign rd_data_o = rd_data_r;

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < chan_cfg_pkg::NUM_CHAN; g++)
    begin : g_chan
      // unpack config fields
      assign cfg_f[g].chained_start = cfg_r[g][chan_cfg_pkg::BIT_CHAINED_START];
      assign cfg_f[g].servo_cont = cfg_r[g][chan_cfg_pkg::BIT_SERVO_CONT];
      assign cfg_f[g].servo_on_warn = cfg_r[g][chan_cfg_pkg::BIT_SERVO_ON_WARN];
      assign cfg_f[g].dac_mode = chan_cfg_pkg::dac_mode_t'(
                                 cfg_r[g][chan_cfg_pkg::POS_DAC_MODE +: 2]);
      assign cfg_f[g].soft_pulldown = cfg_r[g][chan_cfg_pkg::BIT_SOFT_PULLDOWN];
      assign cfg_f[g].dac_gain = cfg_r[g][chan_cfg_pkg::BIT_DAC_GAIN];
      assign cfg_f[g].dac_pol = cfg_r[g][chan_cfg_pkg::BIT_DAC_POL];

      chan_trim_seq u_chan
      (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .cfg_i(cfg_f[g]),
        .cfg_loaded_i(loaded_r),
        .stat_i(stat[g]),
        .trim_o(trim[g]),
        .start_ok_o(start_ok_o[g]),
        .en_fast_pd_o(en_fast_pd_o[g]),
        .en_weak_pd_o(en_weak_pd_o[g]),
        .fault0_event_o(fault0_event_o[g])
      );

      // routing of each channel's faults to the auxiliary pin
      assign ov_hit[g] = stat[g].ov_fault & ov_sel_r[g];
      assign uv_hit[g] = stat[g].uv_fault & uv_sel_r[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // auxiliary fault pin (open drain, low when driven) and alert
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      aux_r <= 1'b0;
    else
      aux_r <= |{ov_hit, uv_hit};
  end

  assign aux_fault_o = 1'b0;
  assign aux_fault_oe_o = aux_r;
  assign alert_n_o = ~|fault0_event_o;

endmodule : channel_trim_and_sequence_config

// File: tb/channel_trim_and_sequence_config_assertions.sv
// checker: port-level relations of the channel trim and sequencing block
`timescale 1ns/100ps
module chan_cfg_checker
(
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic wr_en_i,
  input wire logic [1:0] reg_sel_i,
  input wire logic page_i,
  input wire logic [15:0] wr_data_i,
  input wire chan_cfg_pkg::chan_stat_t stat0_i,
  input wire chan_cfg_pkg::chan_stat_t stat1_i,
  input wire chan_cfg_pkg::trim_ctl_t trim0_o,
  input wire logic [1:0] start_ok_o,
  input wire logic [1:0] en_fast_pd_o,
  input wire logic [1:0] en_weak_pd_o,
  input wire logic [1:0] fault0_event_o,
  input wire logic alert_n_o,
  input wire logic aux_fault_oe_o
);
  logic [15:0] cfg_r [2];
  logic [1:0] ov_r;
  logic [1:0] uv_r;
  logic [7:0] ramp_r;
  wire [1:0] mode0 = cfg_r[0][5:4];
  wire [1:0] ovf = {stat1_i.ov_fault, stat0_i.ov_fault};
  wire [1:0] uvf = {stat1_i.uv_fault, stat0_i.uv_fault};
  wire pull = |((ov_r & ovf) | (uv_r & uvf));
  // shadow copy of what was written to the registers
  always_ff @(posedge clock_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      cfg_r <= '{2{16'h0008}};
      ov_r <= 2'h0;
      uv_r <= 2'h0;
    end
    else if (wr_en_i)
    begin
      if (reg_sel_i == 2'h0)
        cfg_r[page_i] <= (wr_data_i & chan_cfg_pkg::CHANNEL_CONFIG_RO_MASK) | 16'h0008;
      if (reg_sel_i == 2'h1)
        ov_r <= wr_data_i[1:0];
      if (reg_sel_i == 2'h2)
        uv_r <= wr_data_i[1:0];
    end
  // length of the current soft-connect ramp
  always_ff @(posedge clock_i or negedge arst_n_i)
    if (!arst_n_i)
      ramp_r <= 8'h00;
    else
      ramp_r <= trim0_o.soft_ramp ? ramp_r + 8'h01 : 8'h00;
  // ----------------------------------------
  // relations
  // ----------------------------------------
  default clocking dc @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  gain_pol_a: assert property (
    {trim0_o.gain_high, trim0_o.pol_noninv} == cfg_r[0][1:0])
    else $error("gain or polarity off");
  dac_off_a: assert property (
    $past(mode0) == 2'b01 && mode0 == 2'b01 |-> !trim0_o.dac_connect)
    else $error("dac attached in off mode");
  ramp_len_a: assert property (
    $fell(trim0_o.soft_ramp) && $past(stat0_i.on_cmd) |->
    ramp_r == chan_cfg_pkg::SOFT_CONNECT_CYC)
    else $error("soft ramp length wrong");
  servo_go_a: assert property (
    $rose(trim0_o.dac_connect) && mode0 == 2'b00 |-> trim0_o.servo_active)
    else $error("no servo after connect");
  reservo_a: assert property (
    mode0 == 2'b00 && !cfg_r[0][7] && cfg_r[0][6] && stat0_i.warn_hit && stat0_i.on_cmd &&
    stat0_i.rise_done && trim0_o.dac_connect |=> trim0_o.servo_active)
    else $error("no re-servo on warning");
  code_ok_a: assert property (
    trim0_o.code_write_ok |-> trim0_o.dac_connect && !trim0_o.soft_ramp)
    else $error("code write allowed early");
  fast_pd_a: assert property (
    !cfg_r[0][2] && !stat0_i.on_cmd |-> en_fast_pd_o[0] && !en_weak_pd_o[0])
    else $error("fast pull-down missing");
  weak_pd_a: assert property (
    cfg_r[0][2] && stat0_i.soft_stop && !stat0_i.on_cmd && !stat0_i.fault_off |->
    en_weak_pd_o[0] && !en_fast_pd_o[0])
    else $error("weak pull-down missing");
  fault_pd_a: assert property (
    stat0_i.fault_off |-> en_fast_pd_o[0] && !en_weak_pd_o[0])
    else $error("fault off not fast");
  chain_hold_a: assert property (
    cfg_r[1][14] && !stat1_i.control_in && !stat1_i.retry_req |-> !start_ok_o[1])
    else $error("slave started early");
  retry_go_a: assert property (
    cfg_r[1][14] && stat1_i.retry_req |-> start_ok_o[1])
    else $error("retry blocked");
  aux_pull_a: assert property (
    aux_fault_oe_o == $past(pull))
    else $error("aux fault pin wrong");
  alert_a: assert property (
    alert_n_o == !(|fault0_event_o))
    else $error("alert wrong");
  fault0_ev_a: assert property (
    stat0_i.fault0_in |=> fault0_event_o[0] && !alert_n_o)
    else $error("fault line 0 event missing");
  cover property ($rose(trim0_o.code_write_ok));
  cover property ($fell(trim0_o.soft_ramp));
  cover property ($rose(aux_fault_oe_o));
  cover property ($fell(alert_n_o));
endmodule : chan_cfg_checker

// File: tb/conv_model.sv
// model: dc/dc converter whose power good feeds the next channel's control input
`timescale 1ns/100ps
module conv_model
#(
  parameter int RISE_CYC = 20
)
(
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic run_i,
  output logic pgood_o
);
  int cnt;
  // output ramps while run is high; any pull-down drops it at once
  always @(posedge clock_i or negedge arst_n_i)
    if (!arst_n_i || !run_i)
      cnt <= 0;
    else if (cnt < RISE_CYC)
      cnt <= cnt + 1;
  assign pgood_o = (cnt == RISE_CYC);
endmodule : conv_model

// File: tb/test_channel_trim_and_sequence_config.sv
// testbench: registers, dac attach, pull-downs, chained start and fault pins
`timescale 1ns/100ps
module test_channel_trim_and_sequence_config;
  typedef struct {string nm; int idx; logic [15:0] m; logic [15:0] e;} note_t;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic wr_en_i = 1'b0;
  logic [1:0] reg_sel_i = 2'h0;
  logic page_i = 1'b0;
  logic [15:0] wr_data_i = 16'h0000;
  logic restore_i = 1'b0;
  chan_cfg_pkg::chan_stat_t s0 = '0;
  chan_cfg_pkg::chan_stat_t s1 = '0;
  chan_cfg_pkg::chan_stat_t stat1_w;
  chan_cfg_pkg::trim_ctl_t trim0_o;
  logic [15:0] rd_data_o;
  logic [15:0] r;
  logic [1:0] start_ok_o, en_fast_pd_o, en_weak_pd_o, fault0_event_o;
  logic alert_n_o, aux_fault_o, aux_fault_oe_o, pg0;
  logic [15:0] obs [6];
  note_t q [$];
  int n_mismatch = 0, n_checks = 0, seed = 61, cyc = 0;
  // slave control input follows the first supply's power good
  assign stat1_w = {s1[9:3], pg0, s1[1:0]};
  assign obs[0] = rd_data_o;
  assign obs[1] = {9'h000, trim0_o};
  assign obs[2] = {14'h0000, start_ok_o};
  assign obs[3] = {12'h000, en_fast_pd_o, en_weak_pd_o};
  assign obs[4] = {14'h0000, aux_fault_o, aux_fault_oe_o};
  assign obs[5] = {13'h0000, alert_n_o, fault0_event_o};
  channel_trim_and_sequence_config channel_trim_and_sequence_config_inst
  (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .wr_en_i(wr_en_i), .reg_sel_i(reg_sel_i),
    .page_i(page_i), .wr_data_i(wr_data_i), .restore_i(restore_i), .rd_data_o(rd_data_o),
    .stat0_i(s0), .stat1_i(stat1_w), .trim0_o(trim0_o), .trim1_o(),
    .start_ok_o(start_ok_o), .en_fast_pd_o(en_fast_pd_o), .en_weak_pd_o(en_weak_pd_o),
    .fault0_event_o(fault0_event_o), .alert_n_o(alert_n_o), .aux_fault_o(aux_fault_o),
    .aux_fault_oe_o(aux_fault_oe_o)
  );
  conv_model conv_model_inst
  (
    .clock_i(clock_i), .arst_n_i(arst_n_i),
    .run_i(start_ok_o[0] & ~en_fast_pd_o[0] & ~en_weak_pd_o[0]), .pgood_o(pg0)
  );
  // clock and cycle ceiling
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  // compare the oldest note against the settled outputs
  always @(negedge clock_i)
    if (q.size() > 0)
    begin
      n_checks++;
      if ((obs[q[0].idx] & q[0].m) !== q[0].e)
      begin
        n_mismatch++;
        $display("BAD %s exp %h got %h", q[0].nm, q[0].e, obs[q[0].idx] & q[0].m);
      end
      void'(q.pop_front());
    end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input int idx, input logic [15:0] m, input logic [15:0] e);
    q.push_back('{nm, idx, m, e});
    @(negedge clock_i);
    @(posedge clock_i);
  endtask : chk
  task automatic wr(input logic [1:0] sel, input logic pg, input logic [15:0] d);
    @(posedge clock_i);
    wr_en_i <= 1'b1;
    reg_sel_i <= sel;
    page_i <= pg;
    wr_data_i <= d;
    @(posedge clock_i);
    wr_en_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] sel, input logic pg, input logic [15:0] e);
    @(posedge clock_i);
    reg_sel_i <= sel;
    page_i <= pg;
    @(posedge clock_i);
    chk("rd_data_o", 0, 16'hffff, e);
  endtask : rd
  task automatic stop_test;
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // main sequence
  initial
  begin
    repeat (10) @(posedge clock_i);
    arst_n_i <= 1'b1;
    rd(2'h0, 1'b1, 16'h0008);
    rd(2'h2, 1'b0, 16'h0000);
    wr(2'h3, 1'b0, 16'hffff);
    rd(2'h3, 1'b0, 16'h0000);
    wr(2'h1, 1'b0, 16'hfffd);
    rd(2'h1, 1'b0, 16'h0001);
    r = 16'($random(seed));
    wr(2'h0, 1'b1, r | 16'h0008);
    rd(2'h0, 1'b1, (r & chan_cfg_pkg::CHANNEL_CONFIG_RO_MASK) | 16'h0008);
    rd(2'h0, 1'b0, 16'h0008);
    s0 <= 10'h108; // rise time over and a warning level reached
    for (int m = 0; m < 4; m++)
    begin
      wr(2'h0, 1'b0, 16'(m * 16 + 8 + (m ^ 1) + (m == 0 ? 64 : 0)));
      @(posedge clock_i);
      s0.on_cmd <= 1'b1;
      restore_i <= (m == 2);
      repeat (120) @(posedge clock_i);
      r = 16'(((m != 1) << 6) | (((m ^ 1) & 3) << 2) | ((m == 2) << 1) | (m == 3));
      r = r | 16'((m == 0) << 4);
      chk("trim0_o", 1, (m == 3) ? 16'h005f : 16'h005e, r);
      s0.on_cmd <= 1'b0;
      restore_i <= 1'b0;
      repeat (5) @(posedge clock_i);
    end
    chk("pulldown", 3, 16'h0005, 16'h0004);
    wr(2'h0, 1'b0, 16'h000c);
    s0.soft_stop <= 1'b1;
    @(posedge clock_i);
    chk("pulldown", 3, 16'h0005, 16'h0001);
    s0.fault_off <= 1'b1;
    @(posedge clock_i);
    chk("pulldown", 3, 16'h0005, 16'h0004);
    wr(2'h0, 1'b1, 16'h4008);
    s0 <= '0;
    s1.retry_req <= 1'b1;
    @(posedge clock_i);
    chk("start_ok_o", 2, 16'h0002, 16'h0002);
    s1.retry_req <= 1'b0;
    @(posedge clock_i);
    chk("start_ok_o", 2, 16'h0002, 16'h0000);
    s0.on_cmd <= 1'b1;
    repeat (25) @(posedge clock_i);
    chk("start_ok_o", 2, 16'h0002, 16'h0002);
    wr(2'h2, 1'b0, 16'h0002);
    for (int k = 0; k < 4; k++)
    begin
      {s1.uv_fault, s0.uv_fault, s1.ov_fault, s0.ov_fault} <= 4'h1 << (k ^ 1);
      repeat (2) @(posedge clock_i);
      chk("aux_fault", 4, 16'h0003, (k == 1 || k == 2) ? 16'h0001 : 16'h0000);
    end
    s0 <= 10'h001; // off at once, fault line 0 seen
    s1 <= 10'h001; // slave also takes the broadcast off
    repeat (2) @(posedge clock_i);
    chk("fault0", 5, 16'h0007, 16'h0003);
    s0 <= 10'h200;
    s1 <= 10'h200;
    repeat (2) @(posedge clock_i);
    chk("fault0", 5, 16'h0007, 16'h0004);
    stop_test();
  end
endmodule : test_channel_trim_and_sequence_config
bind channel_trim_and_sequence_config chan_cfg_checker chan_cfg_checker_inst (.*);
